// File: rtl/vrf_params.svh
// Constants for the valid/ready look-ahead queue.
// Assumes inclusion by bare name from the queue module only.
`ifndef VRF_PARAMS_SVH
`define VRF_PARAMS_SVH

// Width limits per channel flavour
`define VRF_MAX_STREAM_W  4096
`define VRF_MAX_PLAIN_W   1024
`define VRF_MIN_MM_W      32
`define VRF_MAX_MM_W      1024
`define VRF_LITE_W_A      32
`define VRF_LITE_W_B      64
// Depth and aspect-ratio limits
`define VRF_MAX_DEPTH     131072
`define VRF_MAX_RATIO     8
// Defaults
`define VRF_DEF_W         32
`define VRF_DEF_DEPTH     16
`define VRF_DEF_TH_FULL   12
`define VRF_DEF_TH_EMPTY  2

`endif

// File: rtl/vrf_pkg.sv
// Types shared by the valid/ready look-ahead queue and its bench.
// Assumes no other package.
package vrf_pkg;

  // How the channel is built
  typedef enum logic [1:0] {
    VRF_CFG_FIFO  = 2'h0,
    VRF_CFG_SLICE = 2'h1,
    VRF_CFG_PASS  = 2'h3
  } vrf_cfg_e;

  // Channel flavour, sets the legal widths
  typedef enum logic [1:0] {
    VRF_FLAV_PLAIN  = 2'h0,
    VRF_FLAV_STREAM = 2'h1,
    VRF_FLAV_MM     = 2'h3,
    VRF_FLAV_LITE   = 2'h2
  } vrf_flav_e;

endpackage : vrf_pkg

// File: rtl/vrf_fifo.sv
// Single-clock queue with valid/ready on both sides, look-ahead read side.
// Assumes upstream and downstream logic on clk; reset rstn asynchronous.
//
`timescale 1ns/10ps
`include "vrf_params.svh"

module vrf_fifo #(
  parameter vrf_pkg::vrf_cfg_e  CFG        = vrf_pkg::VRF_CFG_FIFO,
  parameter vrf_pkg::vrf_flav_e FLAV       = vrf_pkg::VRF_FLAV_STREAM,
  parameter int                 WR_W       = `VRF_DEF_W,
  parameter int                 RD_W       = `VRF_DEF_W,
  parameter int                 DEPTH      = `VRF_DEF_DEPTH,
  parameter bit                 LOOK_AHEAD = 1'b1,
  parameter bit                 OUT_REG    = 1'b0,
  parameter bit                 PACKET     = 1'b0,
  parameter int                 LAST_BIT   = 0,
  parameter int                 TH_FULL    = `VRF_DEF_TH_FULL,
  parameter int                 TH_EMPTY   = `VRF_DEF_TH_EMPTY
) (
  // Clock and reset, one domain for both sides
  input  wire logic            clk,
  input  wire logic            rstn,
  // Write side
  input  wire logic            wr_valid,
  output logic                 wr_ready,
  input  wire logic [WR_W-1:0] wr_data,
  // Read side
  output logic                 rd_valid,
  input  wire logic            rd_ready,
  output logic [RD_W-1:0]      rd_data,
  // Status
  output logic                 full_flag,
  output logic                 empty_flag,
  output logic                 near_full_flag,
  output logic                 near_empty_flag,
  output logic                 threshold_full_flag,
  output logic                 threshold_empty_flag
);
  import vrf_pkg::*;

  localparam int MEM_W = (WR_W > RD_W) ? WR_W : RD_W;
  localparam int WR_N  = MEM_W / WR_W;
  localparam int RD_N  = MEM_W / RD_W;
  localparam int AW    = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int OW    = $clog2(DEPTH + 3) + 1;
  localparam int IW    = $clog2(`VRF_MAX_RATIO) + 1;
  localparam bit IS_FIFO = (CFG == VRF_CFG_FIFO);
  localparam int CAP   = (IS_FIFO ? DEPTH : 0) + (LOOK_AHEAD ? 1 + int'(OUT_REG) : 0);

  // Legality of the configuration, checked by assertions below
  localparam bit RATIO_OK = (MEM_W % WR_W == 0) && (MEM_W % RD_W == 0)
                            && (WR_N <= `VRF_MAX_RATIO) && (RD_N <= `VRF_MAX_RATIO);
  localparam bit POW2_OK  = ((WR_W & (WR_W - 1)) == 0);
  localparam bit WIDTH_OK =
    (FLAV == VRF_FLAV_PLAIN)  ? (WR_W >= 1 && MEM_W <= `VRF_MAX_PLAIN_W && RATIO_OK) :
    (FLAV == VRF_FLAV_STREAM) ? (WR_W == RD_W && WR_W >= 1 && WR_W <= `VRF_MAX_STREAM_W) :
    (FLAV == VRF_FLAV_MM)     ? (WR_W == RD_W && POW2_OK && WR_W >= `VRF_MIN_MM_W
                                 && WR_W <= `VRF_MAX_MM_W) :
                                (WR_W == RD_W && (WR_W == `VRF_LITE_W_A
                                 || WR_W == `VRF_LITE_W_B));
  localparam bit DEPTH_OK  = (DEPTH >= 1) && (DEPTH <= `VRF_MAX_DEPTH);
  localparam bit PACKET_OK = !PACKET || (IS_FIFO && WR_N == 1
                             && (FLAV == VRF_FLAV_STREAM || FLAV == VRF_FLAV_MM));
  localparam bit MODE_OK   = (LOOK_AHEAD || (FLAV == VRF_FLAV_PLAIN && IS_FIFO && RD_N == 1));

  // Storage; each entry is the whole information word of one transfer on the wider side
  logic [MEM_W-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr_reg;
  logic [AW-1:0]    rptr_reg;
  logic [OW-1:0]    cnt_reg;
  logic [OW-1:0]    cnt_next;
  logic [OW-1:0]    pkt_reg;
  logic [OW-1:0]    occ_next;
  // Narrow-write gathering and narrow-read scattering
  logic [MEM_W-1:0] acc_reg;
  logic [IW-1:0]    wi_reg;
  logic [IW-1:0]    ri_reg;
  // Output stages; s1 exists only with the output register
  logic             s0_v_reg;
  logic [MEM_W-1:0] s0_d_reg;
  logic             s1_v_reg;
  logic [MEM_W-1:0] s1_d_reg;
  logic             s0_v_next;
  logic             s1_v_next;
  logic             wr_ready_reg;
  logic             wr_ready_next;
  logic             full_reg;
  logic             empty_reg;
  logic             nfull_reg;
  logic             nempty_reg;
  logic             thf_reg;
  logic             the_reg;

  logic             wr_fire;
  logic             push;
  logic [MEM_W-1:0] push_word;
  logic             out_v;
  logic [MEM_W-1:0] out_d;
  logic             out_cons;
  logic             s1_free;
  logic             s0_leave;
  logic             s0_free;
  logic             src_ok;
  logic             pop;
  logic             load;
  logic [MEM_W-1:0] ld_data;

  always_comb begin
    wr_fire   = wr_valid && wr_ready_reg;
    push      = wr_fire && (wi_reg == IW'(WR_N - 1));
    push_word = acc_reg;
    push_word[int'(wi_reg) * WR_W +: WR_W] = wr_data;
    out_v     = OUT_REG ? s1_v_reg : s0_v_reg;
    out_d     = OUT_REG ? s1_d_reg : s0_d_reg;
    // Standard mode shows a word for one cycle only
    out_cons  = LOOK_AHEAD ? (out_v && rd_ready && ri_reg == IW'(RD_N - 1)) : out_v;
    s1_free   = !s1_v_reg || out_cons;
    s0_leave  = OUT_REG ? (s0_v_reg && s1_free) : out_cons;
    s0_free   = !s0_v_reg || s0_leave;
    // Packet mode holds the head back until a whole packet is stored
    src_ok    = (cnt_reg != '0) && (!PACKET || pkt_reg != '0);
    if (!IS_FIFO) begin
      pop  = 1'b0;
      load = push;
    end else if (LOOK_AHEAD) begin
      pop  = src_ok && s0_free;
      load = pop;
    end else begin
      pop  = rd_ready && cnt_reg != '0;
      load = pop;
    end
    ld_data   = IS_FIFO ? mem[rptr_reg] : push_word;
    s0_v_next = load || (s0_v_reg && !s0_leave);
    s1_v_next = OUT_REG && ((s0_leave) || (s1_v_reg && !out_cons));
    cnt_next  = cnt_reg + OW'(push && IS_FIFO) - OW'(pop);
    // Slice takes a word only into an emptied stage; keeps ready a flop
    wr_ready_next = IS_FIFO ? (cnt_next != OW'(DEPTH)) : !s0_v_next;
    occ_next  = LOOK_AHEAD ? (cnt_next + OW'(s0_v_next) + OW'(s1_v_next)) : cnt_next;
  end

  // Storage write; no reset so it maps to memory
  always_ff @(posedge clk) begin
    if (push && IS_FIFO) begin
      mem[wptr_reg] <= push_word;
    end
  end

  // Pointers and counts
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg  <= '0;
      pkt_reg  <= '0;
    end else begin
      if (push && IS_FIFO) begin
        wptr_reg <= (wptr_reg == AW'(DEPTH - 1)) ? '0 : wptr_reg + AW'(1);
      end
      if (pop) begin
        rptr_reg <= (rptr_reg == AW'(DEPTH - 1)) ? '0 : rptr_reg + AW'(1);
      end
      cnt_reg <= cnt_next;
      if (PACKET) begin
        pkt_reg <= pkt_reg + OW'(push && push_word[LAST_BIT])
                           - OW'(pop && mem[rptr_reg][LAST_BIT]);
      end
    end
  end

  // Width conversion indices
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_reg <= '0;
      wi_reg  <= '0;
      ri_reg  <= '0;
    end else begin
      if (wr_fire && WR_N > 1) begin
        acc_reg <= push_word;
        wi_reg  <= push ? '0 : wi_reg + IW'(1);
      end
      if (LOOK_AHEAD && out_v && rd_ready && RD_N > 1) begin
        ri_reg <= (ri_reg == IW'(RD_N - 1)) ? '0 : ri_reg + IW'(1);
      end
    end
  end

  // Output stages
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s0_v_reg <= 1'b0;
      s0_d_reg <= '0;
      s1_v_reg <= 1'b0;
      s1_d_reg <= '0;
    end else begin
      s0_v_reg <= s0_v_next;
      if (load) begin
        s0_d_reg <= ld_data;
      end
      s1_v_reg <= s1_v_next;
      if (OUT_REG && s0_leave) begin
        s1_d_reg <= s0_d_reg;
      end
    end
  end

  // Ready and status flags
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ready_reg <= 1'b0;
      full_reg     <= 1'b0;
      empty_reg    <= 1'b1;
      nfull_reg    <= 1'b0;
      nempty_reg   <= 1'b0;
      thf_reg      <= 1'b0;
      the_reg      <= 1'b1;
    end else begin
      wr_ready_reg <= wr_ready_next;
      full_reg     <= (occ_next == OW'(CAP));
      empty_reg    <= (occ_next == '0);
      nfull_reg    <= (occ_next == OW'(CAP - 1));
      nempty_reg   <= (occ_next == OW'(1));
      thf_reg      <= (occ_next >= OW'(TH_FULL));
      the_reg      <= (occ_next <= OW'(TH_EMPTY));
    end
  end

  // Pass-through is a bare wire by definition
  generate
    if (CFG == VRF_CFG_PASS) begin : g_pass
      assign wr_ready = rd_ready;
      assign rd_valid = wr_valid;
      assign rd_data  = RD_W'(wr_data);
    end else begin : g_store
      assign wr_ready = wr_ready_reg;
      assign rd_valid = out_v;
      assign rd_data  = out_d[int'(ri_reg) * RD_W +: RD_W];
    end
  endgenerate

  assign full_flag            = full_reg;
  assign empty_flag           = empty_reg;
  assign near_full_flag       = nfull_reg;
  assign near_empty_flag      = nempty_reg;
  assign threshold_full_flag  = thf_reg;
  assign threshold_empty_flag = the_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_width_legal;
    1'b1 |-> WIDTH_OK;
  endproperty
  a_width_legal : assert property (p_width_legal)
    else $error("illegal word width for flavour");

  property p_depth_legal;
    1'b1 |-> DEPTH_OK && PACKET_OK && MODE_OK;
  endproperty
  a_depth_legal : assert property (p_depth_legal)
    else $error("illegal depth, packet or read mode setting");

  property p_no_overwrite;
    (push && IS_FIFO) |-> cnt_reg != OW'(DEPTH);
  endproperty
  a_no_overwrite : assert property (p_no_overwrite)
    else $error("entry overwritten while full");

  property p_refused_write;
    (CFG != VRF_CFG_PASS && !wr_ready) |=> $stable(wptr_reg) && $stable(wi_reg);
  endproperty
  a_refused_write : assert property (p_refused_write)
    else $error("refused write moved the write pointer");

  // Ready is a flop, so skip the first edge out of reset
  property p_ready_tracks_space;
    (IS_FIFO && $past(rstn) && $past(cnt_next) != OW'(DEPTH)) |-> wr_ready;
  endproperty
  a_ready_tracks_space : assert property (p_ready_tracks_space)
    else $error("write ready low while space remains");

  property p_hold_until_taken;
    (LOOK_AHEAD && CFG != VRF_CFG_PASS && rd_valid && !rd_ready)
      |=> rd_valid && $stable(rd_data);
  endproperty
  a_hold_until_taken : assert property (p_hold_until_taken)
    else $error("read word dropped before taken");

  property p_fall_through;
    (LOOK_AHEAD && IS_FIFO && !PACKET && cnt_reg != '0 && !rd_valid)
      |-> ##[1:2] rd_valid;
  endproperty
  a_fall_through : assert property (p_fall_through)
    else $error("stored word did not fall through");

  property p_latency_plain;
    (LOOK_AHEAD && IS_FIFO && !PACKET && !OUT_REG && WR_N == 1 && empty_flag && push)
      |-> !rd_valid ##1 !rd_valid ##1 rd_valid;
  endproperty
  a_latency_plain : assert property (p_latency_plain)
    else $error("empty-queue latency is not two cycles");

  property p_latency_outreg;
    (LOOK_AHEAD && IS_FIFO && !PACKET && OUT_REG && WR_N == 1 && empty_flag && push)
      |-> !rd_valid [*3] ##1 rd_valid;
  endproperty
  a_latency_outreg : assert property (p_latency_outreg)
    else $error("output register latency is not three cycles");

  property p_full_blocks;
    (IS_FIFO && full_flag) |-> !wr_ready && !near_full_flag;
  endproperty
  a_full_blocks : assert property (p_full_blocks)
    else $error("full queue still accepting");

  property p_empty_no_valid;
    (LOOK_AHEAD && CFG != VRF_CFG_PASS && empty_flag) |-> !rd_valid && threshold_empty_flag;
  endproperty
  a_empty_no_valid : assert property (p_empty_no_valid)
    else $error("empty queue presenting a word");

  property p_near_full_alone;
    (CAP > 1 && near_full_flag) |-> !full_flag && !empty_flag;
  endproperty
  a_near_full_alone : assert property (p_near_full_alone)
    else $error("near-full flag overlaps full or empty");

  property p_cov_fill;
    full_flag ##1 (rd_valid && rd_ready);
  endproperty
  c_fill : cover property (p_cov_fill);

  property p_cov_stream;
    (wr_valid && wr_ready && rd_valid && rd_ready) [*3];
  endproperty
  c_stream : cover property (p_cov_stream);

  property p_cov_threshold;
    $rose(threshold_full_flag) ##[1:20] $rose(threshold_empty_flag);
  endproperty
  c_threshold : cover property (p_cov_threshold);

  property p_cov_held_word;
    (rd_valid && !rd_ready) ##1 (rd_valid && rd_ready);
  endproperty
  c_held_word : cover property (p_cov_held_word);

  property p_cov_near_full;
    near_full_flag ##1 full_flag;
  endproperty
  c_near_full : cover property (p_cov_near_full);

endmodule : vrf_fifo

// File: tb/vrf_stream_partner.sv
// Upstream source and downstream sink placed around the queue.
// Assumes one clock shared with the queue; counters clear while rstn is low.
`timescale 1ns/10ps
module vrf_stream_partner #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Bench control
  input  wire logic [15:0]  tx_limit,
  input  wire logic [15:0]  rx_limit,
  input  wire logic         rx_alt,
  // Queue write side
  output logic              wr_valid,
  input  wire logic         wr_ready,
  output logic [W-1:0]      wr_data,
  // Queue read side
  input  wire logic         rd_valid,
  output logic              rd_ready,
  input  wire logic [W-1:0] rd_data,
  // Results
  output logic [15:0]       tx_count,
  output logic [15:0]       rx_count,
  output logic [15:0]       rx_bad
);
  logic [15:0] tx_next;
  logic [15:0] rx_next;

  assign tx_next = tx_count + 16'(wr_valid && wr_ready);
  assign rx_next = rx_count + 16'(rd_valid && rd_ready);

  // Source holds each word until it is taken
  always @(posedge clk) begin
    if (!rstn) begin
      wr_valid <= 1'b0;
      wr_data  <= '0;
      tx_count <= '0;
    end else begin
      tx_count <= tx_next;
      if (!wr_valid || wr_ready) begin
        wr_valid <= tx_next < tx_limit;
        // Idle data flips so a stale word never passes for a fresh one
        wr_data  <= (tx_next < tx_limit) ? W'(tx_next) : ~wr_data;
      end
    end
  end

  // Sink counts words and checks their order
  always @(posedge clk) begin
    if (!rstn) begin
      rd_ready <= 1'b0;
      rx_count <= '0;
      rx_bad   <= '0;
    end else begin
      rx_count <= rx_next;
      rd_ready <= (rx_next < rx_limit) && !(rx_alt && rd_ready);
      if (rd_valid && rd_ready && rd_data !== W'(rx_count)) begin
        rx_bad <= rx_bad + 16'h0001;
      end
    end
  end
endmodule : vrf_stream_partner

// File: tb/vrf_fifo_tb_top.sv
// Self-checking bench for the look-ahead queue with a stream partner.
// Assumes the partner drives both handshakes; limits steer its traffic.
`timescale 1ns/10ps
module vrf_fifo_tb_top;
  import vrf_pkg::*;
  localparam int W     = 8;
  localparam int DEPTH = 4;
  localparam int CAP   = DEPTH + 1;
  localparam int TH_F  = 3;
  localparam int TH_E  = 1;

  logic         clk;
  logic         rstn;
  logic         wr_valid;
  logic         wr_ready;
  logic [W-1:0] wr_data;
  logic         rd_valid;
  logic         rd_ready;
  logic [W-1:0] rd_data;
  logic         full_flag;
  logic         empty_flag;
  logic         near_full_flag;
  logic         near_empty_flag;
  logic         threshold_full_flag;
  logic         threshold_empty_flag;
  logic [15:0]  tx_limit;
  logic [15:0]  rx_limit;
  logic         rx_alt;
  logic [15:0]  tx_count;
  logic [15:0]  rx_count;
  logic [15:0]  rx_bad;
  int           n_mismatch = 0;
  int           n_checks   = 0;

  vrf_fifo #(
    .FLAV     (VRF_FLAV_STREAM),
    .WR_W     (W),
    .RD_W     (W),
    .DEPTH    (DEPTH),
    .TH_FULL  (TH_F),
    .TH_EMPTY (TH_E)
  ) u_dut (
    .clk                  (clk),
    .rstn                 (rstn),
    .wr_valid             (wr_valid),
    .wr_ready             (wr_ready),
    .wr_data              (wr_data),
    .rd_valid             (rd_valid),
    .rd_ready             (rd_ready),
    .rd_data              (rd_data),
    .full_flag            (full_flag),
    .empty_flag           (empty_flag),
    .near_full_flag       (near_full_flag),
    .near_empty_flag      (near_empty_flag),
    .threshold_full_flag  (threshold_full_flag),
    .threshold_empty_flag (threshold_empty_flag)
  );

  vrf_stream_partner #(
    .W (W)
  ) u_partner (
    .clk      (clk),
    .rstn     (rstn),
    .tx_limit (tx_limit),
    .rx_limit (rx_limit),
    .rx_alt   (rx_alt),
    .wr_valid (wr_valid),
    .wr_ready (wr_ready),
    .wr_data  (wr_data),
    .rd_valid (rd_valid),
    .rd_ready (rd_ready),
    .rd_data  (rd_data),
    .tx_count (tx_count),
    .rx_count (rx_count),
    .rx_bad   (rx_bad)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic stop_test();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask : cycles

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  // Bounded wait for the partner to reach both limits
  task automatic wait_done();
    int n;
    n = 0;
    cycles(1);
    while ((tx_count !== tx_limit || rx_count !== rx_limit) && n < 400) begin
      cycles(1);
      n++;
    end
    check("done_wait", 16'h0000, 16'(n >= 400));
  endtask : wait_done

  // Flags include the output stage, so CAP is one above DEPTH
  task automatic chk_occ(input int occ);
    // Look between edges, where registered outputs have settled
    cycles(3);
    @(negedge clk);
    check("wr_ready", 16'(occ < CAP), 16'(wr_ready));
    check("rd_valid", 16'(occ > 0), 16'(rd_valid));
    check("full_flag", 16'(occ == CAP), 16'(full_flag));
    check("empty_flag", 16'(occ == 0), 16'(empty_flag));
    check("near_full_flag", 16'(occ == CAP - 1), 16'(near_full_flag));
    check("near_empty_flag", 16'(occ == 1), 16'(near_empty_flag));
    check("threshold_full_flag", 16'(occ >= TH_F), 16'(threshold_full_flag));
    check("threshold_empty_flag", 16'(occ <= TH_E), 16'(threshold_empty_flag));
    if (occ > 0) begin
      check("rd_data", 16'(rx_limit[7:0]), 16'(rd_data));
    end
    @(posedge clk);
  endtask : chk_occ

  // Fill one word at a time, push against full, then drain with refill
  task automatic t_levels();
    chk_occ(0);
    for (int i = 1; i <= CAP; i++) begin
      tx_limit <= 16'(i);
      chk_occ(i);
    end
    tx_limit <= 16'(CAP + 3);
    cycles(6);
    check("tx_count", 16'(CAP), tx_count);
    for (int i = 1; i <= CAP + 3; i++) begin
      rx_limit <= 16'(i);
      chk_occ((CAP + 3 - i > CAP) ? CAP : CAP + 3 - i);
    end
  endtask : t_levels

  task automatic t_stream(input logic alt);
    rx_alt   <= alt;
    tx_limit <= tx_limit + 16'h0028;
    rx_limit <= rx_limit + 16'h0028;
    wait_done();
    check("rx_count", tx_limit, rx_count);
    check("rx_bad", 16'h0000, rx_bad);
  endtask : t_stream

  task automatic t_mid_reset();
    rx_alt   <= 1'b0;
    tx_limit <= tx_limit + 16'h0003;
    cycles(6);
    rstn <= 1'b0;
    cycles(2);
    check("wr_ready", 16'h0000, 16'(wr_ready));
    check("rd_valid", 16'h0000, 16'(rd_valid));
    check("empty_flag", 16'h0001, 16'(empty_flag));
    tx_limit <= '0;
    rx_limit <= '0;
    rstn     <= 1'b1;
    chk_occ(0);
  endtask : t_mid_reset

  initial begin
    rstn     = 1'b0;
    tx_limit = '0;
    rx_limit = '0;
    rx_alt   = 1'b0;
    cycles(4);
    rstn <= 1'b1;
    cycles(2);
    t_levels();
    t_stream(1'b1);
    t_stream(1'b0);
    t_mid_reset();
    t_stream(1'b0);
    stop_test();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    cycles(4000);
    n_mismatch++;
    stop_test();
  end
endmodule : vrf_fifo_tb_top
